// *** rtl/sxe_pkg.sv ***
// Purpose : Shared constants and carriers for the two-wire bus extension block
// Assumes : 200 MHz main clock, 32 kHz slow timing clock
// Notes   : Offsets are byte addresses of 32-bit words
package sxe_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL_A = 8'h00;
  localparam logic [7:0] OFS_CONTROL_B = 8'h04;
  localparam logic [7:0] OFS_LENGTH    = 8'h08;
  localparam logic [7:0] OFS_DATA      = 8'h0C;
  localparam logic [7:0] OFS_STATUS    = 8'h10;
  localparam logic [7:0] OFS_MASK      = 8'h14;
  localparam logic [7:0] OFS_STATE     = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CA_LOWTO  = 0;  // scl_low_timeout_en
  localparam int CA_SEXTTO = 1;  // slave_extend_timeout_en
  localparam int CA_MEXTTO = 2;  // master_extend_timeout_en
  localparam int CA_4WIRE  = 3;  // four_wire_pin_sel
  localparam int CB_SMART  = 0;  // smart_mode_en
  localparam int CB_ACK_ACTION = 1;  // ack_action, 1 = NACK
  localparam int LN_EN     = 8;  // length_count_en above transfer_length[7:0]

  localparam int ST_LOWTO  = 0;
  localparam int ST_SEXTTO = 1;
  localparam int ST_MEXTTO = 2;
  localparam int ST_LENGTH_ERROR = 3;
  localparam int ST_MOB    = 4;  // master_on_bus_flag
  localparam int ST_STOP   = 5;  // stop_received_flag
  localparam int ST_ERROR  = 6;
  localparam int ST_AMATCH = 7;  // address_match_flag
  localparam int ST_W      = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0]      RST_CONTROL_A = 4'h0;
  localparam logic [1:0]      RST_CONTROL_B = 2'h0;
  localparam logic [8:0]      RST_LENGTH    = 9'h000;
  localparam logic [ST_W-1:0] RST_STATUS    = 8'h00;
  localparam logic [ST_W-1:0] RST_MASK      = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ       = 200;
  localparam int SDA_HOLD_NS   = 300;
  localparam int SDA_HOLD_CYC  = (SDA_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int SLOW_HZ       = 32000;
  localparam int T_TIMEOUT_MS  = 25;
  localparam int T_SEXT_MS     = 25;
  localparam int T_MEXT_MS     = 10;
  localparam int TICKS_TIMEOUT = (T_TIMEOUT_MS * SLOW_HZ + 999) / 1000;
  localparam int TICKS_SEXT    = (T_SEXT_MS * SLOW_HZ + 999) / 1000;
  localparam int TICKS_MEXT    = (T_MEXT_MS * SLOW_HZ + 999) / 1000;

  // ----------------------------------------------------------------
  // Carriers between this block and the byte engine beside it
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       is_master;    // Engine acts as master
    logic       is_read;      // Current transfer is a master read
    logic       rx_byte;      // Pulse: byte received
    logic       tx_need;      // Pulse: byte needed for sending
    logic       ack_slot;     // Pulse: ack bit of a byte (address too)
    logic       addr_ack;     // Pulse: ack slot belongs to address byte
    logic       addr_match;   // Pulse: slave address matched
    logic       on_bus;       // Pulse: master owns the bus
    logic       rx_nack;      // Pulse: NACK seen on a master write
    logic       bus_err;      // Pulse: illegal bus condition
    logic       own_stretch;  // Level: engine holds SCL low to stretch
    logic       scl_low_req;  // Level: engine wants SCL low
    logic       sda_low_req;  // Level: engine wants SDA low
    logic [7:0] rx_data;      // Received byte, valid with rx_byte
  } sxe_core_t;

  typedef struct packed {
    logic       ack_go;       // Pulse: send ack bit now
    logic       ack_nack;     // Value of that bit, 1 = NACK
    logic       auto_nack;    // Pulse: NACK the last read byte
    logic       auto_stop;    // Pulse: issue STOP
    logic       tx_valid;     // Level: tx_data holds a fresh byte
    logic [7:0] tx_data;      // Byte to send
  } sxe_ctl_t;

endpackage : sxe_pkg

// *** rtl/sxe_ext.sv ***
// Purpose : Timeouts, SDA hold, smart ack, pin mode and DMA requests
//           for a two-wire bus master/slave engine
// Assumes : Pins and slow clock are asynchronous to mclk
// Notes   : Status bits clear on read; a set in the same cycle wins
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - SCL-low timeout counters advance on rising edges of the separate 32 kHz slow timing clock.
// - With scl_low_timeout_en set, one SCL low period of 25 ms flags a timeout.
// - With slave_extend_timeout_en set, slave stretching summed from START to STOP flags at 25 ms.
// - With master_extend_timeout_en set, master stretching summed within one byte span flags at 10 ms.
// - Driven SDA changes are held back after SCL falls for an SMBus-compatible hold time.
// - In smart mode a read of DATA with a received byte pending sends ACK or NACK as ack_action selects.
// - Setting four_wire_pin_sel to 1 selects 4-wire operation with separate line signals.
// - In 4-wire mode internal tri-state drivers are bypassed and an external driver joins the bus.
// - A slave address match raises address_match_flag and DMA waits until it is serviced.
// - As slave, receive DMA request rises on a written byte and falls on a DATA read.
// - As slave, transmit DMA request rises when a byte is needed and falls on a DATA write.
// - As master, transmit DMA request rises when write data is needed and falls on a DATA write.
// - As master, receive DMA request rises when read data arrives and falls on a DATA read.
// - With length_count_en the master moves transfer_length bytes, NACKs a last read and issues STOP.
// - A NACK on a master write before the length issues STOP and raises length_error and error.
module sxe_ext
  import sxe_pkg::*;
#(
  parameter int CNT_W = 12
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Slow timing clock, sampled
  input  wire logic        slow_timeout_clock,
  // Byte engine
  input  wire sxe_core_t   core,
  output sxe_ctl_t         ctl,
  output logic             line_scl,
  output logic             line_sda,
  // DMA and interrupt
  output logic             dma_rx_req,
  output logic             dma_tx_req,
  output logic             irq,
  // Two-wire pins
  input  wire logic        pad_scl_i,
  output logic             pad_scl_o,
  output logic             pad_scl_oe,
  input  wire logic        pad_sda_i,
  output logic             pad_sda_o,
  output logic             pad_sda_oe,
  // Four-wire pins
  input  wire logic        ext_scl_i,
  input  wire logic        ext_sda_i,
  output logic             ext_scl_o,
  output logic             ext_sda_o
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [4:0] sync1_r, sync2_r, sync_nxt;
  logic       slow_q_r, slow_q_nxt, scl_q_r, scl_q_nxt, sda_q_r, sda_q_nxt;

  // Two flops per asynchronous input
  always_comb begin
    sync_nxt = {slow_timeout_clock, ext_sda_i, ext_scl_i, pad_sda_i, pad_scl_i};
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync1_r <= 5'h1F;
      sync2_r <= 5'h1F;
    end else begin
      sync1_r <= sync_nxt;
      sync2_r <= sync1_r;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [3:0]      ctrl_a_r, ctrl_a_nxt;
  logic [1:0]      ctrl_b_r, ctrl_b_nxt;
  logic [8:0]      length_r, length_nxt;
  logic [7:0]      tx_data_r, tx_data_nxt;
  logic [ST_W-1:0] mask_r, mask_nxt;
  logic            wr_data, rd_data, rd_status;

  assign wr_data   = reg_wr && (reg_addr == OFS_DATA);
  assign rd_data   = reg_rd && (reg_addr == OFS_DATA);
  assign rd_status = reg_rd && (reg_addr == OFS_STATUS);

  // Register writes
  always_comb begin
    ctrl_a_nxt  = ctrl_a_r;
    ctrl_b_nxt  = ctrl_b_r;
    length_nxt  = length_r;
    tx_data_nxt = tx_data_r;
    mask_nxt    = mask_r;
    if (reg_wr) begin
      if (reg_addr == OFS_CONTROL_A) begin
        ctrl_a_nxt = reg_wdata[3:0];
      end else if (reg_addr == OFS_CONTROL_B) begin
        ctrl_b_nxt = reg_wdata[1:0];
      end else if (reg_addr == OFS_LENGTH) begin
        length_nxt = reg_wdata[8:0];
      end else if (reg_addr == OFS_DATA) begin
        tx_data_nxt = reg_wdata[7:0];
      end else if (reg_addr == OFS_MASK) begin
        mask_nxt = reg_wdata[ST_W-1:0];
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_a_r  <= RST_CONTROL_A;
      ctrl_b_r  <= RST_CONTROL_B;
      length_r  <= RST_LENGTH;
      tx_data_r <= 8'h00;
      mask_r    <= RST_MASK;
    end else begin
      ctrl_a_r  <= ctrl_a_nxt;
      ctrl_b_r  <= ctrl_b_nxt;
      length_r  <= length_nxt;
      tx_data_r <= tx_data_nxt;
      mask_r    <= mask_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Line selection and bus conditions
  // ----------------------------------------------------------------
  logic four_wire, slow_tick, scl_fall, start_det, stop_det;

  assign four_wire = ctrl_a_r[CA_4WIRE];

  // Line levels from the selected pin pair, edge detection
  always_comb begin
    slow_q_nxt = sync2_r[4];
    scl_q_nxt  = four_wire ? sync2_r[2] : sync2_r[0];
    sda_q_nxt  = four_wire ? sync2_r[3] : sync2_r[1];
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      slow_q_r <= 1'b1;
      scl_q_r  <= 1'b1;
      sda_q_r  <= 1'b1;
    end else begin
      slow_q_r <= slow_q_nxt;
      scl_q_r  <= scl_q_nxt;
      sda_q_r  <= sda_q_nxt;
    end
  end

  assign slow_tick = slow_q_nxt && !slow_q_r;
  assign scl_fall  = scl_q_r && !scl_q_nxt;
  assign start_det = scl_q_r && scl_q_nxt && sda_q_r && !sda_q_nxt;
  assign stop_det  = scl_q_r && scl_q_nxt && !sda_q_r && sda_q_nxt;
  assign line_scl  = scl_q_r;
  assign line_sda  = sda_q_r;

  // ----------------------------------------------------------------
  // Timeout counters on the slow tick
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] low_cnt_r, low_cnt_nxt, sext_cnt_r, sext_cnt_nxt;
  logic [CNT_W-1:0] mext_cnt_r, mext_cnt_nxt;
  logic             low_to, sext_to, mext_to;

  // Single low period, slave sum per message, master sum per byte span
  always_comb begin
    low_cnt_nxt  = low_cnt_r;
    sext_cnt_nxt = sext_cnt_r;
    mext_cnt_nxt = mext_cnt_r;
    if (scl_q_r || !ctrl_a_r[CA_LOWTO]) begin
      low_cnt_nxt = '0;
    end else if (slow_tick && low_cnt_r != CNT_W'(TICKS_TIMEOUT)) begin
      low_cnt_nxt = low_cnt_r + 1'b1;
    end
    if (start_det || stop_det || !ctrl_a_r[CA_SEXTTO]) begin
      sext_cnt_nxt = '0;
    end else if (slow_tick && core.own_stretch && !core.is_master
                 && sext_cnt_r != CNT_W'(TICKS_SEXT)) begin
      sext_cnt_nxt = sext_cnt_r + 1'b1;
    end
    if (start_det || stop_det || core.ack_slot || !ctrl_a_r[CA_MEXTTO]) begin
      mext_cnt_nxt = '0;
    end else if (slow_tick && core.own_stretch && core.is_master
                 && mext_cnt_r != CNT_W'(TICKS_MEXT)) begin
      mext_cnt_nxt = mext_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      low_cnt_r  <= '0;
      sext_cnt_r <= '0;
      mext_cnt_r <= '0;
    end else begin
      low_cnt_r  <= low_cnt_nxt;
      sext_cnt_r <= sext_cnt_nxt;
      mext_cnt_r <= mext_cnt_nxt;
    end
  end

  // One-cycle pulses when a count first reaches its limit
  assign low_to  = (low_cnt_nxt == CNT_W'(TICKS_TIMEOUT)) && (low_cnt_r != CNT_W'(TICKS_TIMEOUT));
  assign sext_to = (sext_cnt_nxt == CNT_W'(TICKS_SEXT)) && (sext_cnt_r != CNT_W'(TICKS_SEXT));
  assign mext_to = (mext_cnt_nxt == CNT_W'(TICKS_MEXT)) && (mext_cnt_r != CNT_W'(TICKS_MEXT));

  // ----------------------------------------------------------------
  // SDA hold and pin drivers
  // ----------------------------------------------------------------
  logic [7:0] hold_cnt_r, hold_cnt_nxt;
  logic       sda_drv_r, sda_drv_nxt, scl_drv_r, scl_drv_nxt, scl_own_fall;

  // Own SCL pull starts the hold before the synchronised line shows it
  assign scl_own_fall = core.scl_low_req && !scl_drv_r;

  // Freeze SDA for the hold time after each SCL fall
  always_comb begin
    hold_cnt_nxt = hold_cnt_r;
    if (scl_fall || scl_own_fall) begin
      hold_cnt_nxt = 8'(SDA_HOLD_CYC);
    end else if (hold_cnt_r != 8'h00) begin
      hold_cnt_nxt = hold_cnt_r - 8'h01;
    end
    sda_drv_nxt = (hold_cnt_r != 8'h00 || scl_fall || scl_own_fall) ? sda_drv_r : core.sda_low_req;
    scl_drv_nxt = core.scl_low_req;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hold_cnt_r <= 8'h00;
      sda_drv_r  <= 1'b0;
      scl_drv_r  <= 1'b0;
    end else begin
      hold_cnt_r <= hold_cnt_nxt;
      sda_drv_r  <= sda_drv_nxt;
      scl_drv_r  <= scl_drv_nxt;
    end
  end

  // Open drain in 2-wire mode; push levels to an external driver in 4-wire
  assign pad_scl_o  = 1'b0;
  assign pad_sda_o  = 1'b0;
  assign pad_scl_oe = !four_wire && scl_drv_r;
  assign pad_sda_oe = !four_wire && sda_drv_r;
  assign ext_scl_o  = four_wire ? !scl_drv_r : 1'b1;
  assign ext_sda_o  = four_wire ? !sda_drv_r : 1'b1;

  // ----------------------------------------------------------------
  // Length counter and automatic NACK/STOP
  // ----------------------------------------------------------------
  logic [7:0] left_r, left_nxt;
  logic       len_act_r, len_act_nxt, auto_stop, auto_nack, len_err;

  // Load on LENGTH write, count down on data ack slots
  always_comb begin
    left_nxt    = left_r;
    len_act_nxt = len_act_r;
    auto_stop   = 1'b0;
    auto_nack   = 1'b0;
    len_err     = 1'b0;
    if (reg_wr && reg_addr == OFS_LENGTH) begin
      left_nxt    = reg_wdata[7:0];
      len_act_nxt = reg_wdata[LN_EN];
    end else if (len_act_r && core.is_master) begin
      if (core.rx_nack && !core.is_read && left_r != 8'h00) begin
        auto_stop   = 1'b1;
        len_err     = 1'b1;
        len_act_nxt = 1'b0;
      end else if (core.ack_slot && core.addr_ack) begin
        if (left_r == 8'h00) begin
          auto_stop   = 1'b1;
          len_act_nxt = 1'b0;
        end
      end else if (core.ack_slot) begin
        left_nxt = left_r - 8'h01;
        if (left_r == 8'h01) begin
          auto_nack   = core.is_read;
          auto_stop   = 1'b1;
          len_act_nxt = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      left_r    <= 8'h00;
      len_act_r <= 1'b0;
    end else begin
      left_r    <= left_nxt;
      len_act_r <= len_act_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Status flags, DMA requests, smart ack
  // ----------------------------------------------------------------
  logic [ST_W-1:0] status_r, status_nxt, ev_set;
  logic [7:0]      rx_data_r, rx_data_nxt;
  logic            rx_req_r, rx_req_nxt, tx_req_r, tx_req_nxt;
  logic            ack_go_r, ack_go_nxt, nack_r, nack_nxt, slave_hold;

  // Events that set sticky bits
  always_comb begin
    ev_set             = '0;
    ev_set[ST_LOWTO]   = low_to;
    ev_set[ST_SEXTTO]  = sext_to;
    ev_set[ST_MEXTTO]  = mext_to;
    ev_set[ST_LENGTH_ERROR]  = len_err;
    ev_set[ST_MOB]     = core.on_bus;
    ev_set[ST_STOP]    = stop_det;
    ev_set[ST_ERROR]   = core.bus_err || low_to || sext_to || mext_to || len_err;
    ev_set[ST_AMATCH]  = core.addr_match && !core.is_master;
  end

  // Slave data waits while address_match_flag is unserviced
  assign slave_hold = !core.is_master && status_r[ST_AMATCH];

  always_comb begin
    status_nxt  = (rd_status ? '0 : status_r) | ev_set;
    rx_data_nxt = core.rx_byte ? core.rx_data : rx_data_r;
    rx_req_nxt  = rx_req_r;
    tx_req_nxt  = tx_req_r;
    if (rd_data) begin
      rx_req_nxt = 1'b0;
    end
    if (core.rx_byte) begin
      rx_req_nxt = 1'b1;
    end
    if (wr_data) begin
      tx_req_nxt = 1'b0;
    end
    if (core.tx_need) begin
      tx_req_nxt = 1'b1;
    end
    ack_go_nxt = rd_data && ctrl_b_r[CB_SMART] && rx_req_r;
    nack_nxt   = ctrl_b_r[CB_ACK_ACTION];
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status_r  <= RST_STATUS;
      rx_data_r <= 8'h00;
      rx_req_r  <= 1'b0;
      tx_req_r  <= 1'b0;
      ack_go_r  <= 1'b0;
      nack_r    <= 1'b0;
    end else begin
      status_r  <= status_nxt;
      rx_data_r <= rx_data_nxt;
      rx_req_r  <= rx_req_nxt;
      tx_req_r  <= tx_req_nxt;
      ack_go_r  <= ack_go_nxt;
      nack_r    <= nack_nxt;
    end
  end

  assign dma_rx_req = rx_req_r && !slave_hold;
  assign dma_tx_req = tx_req_r && !slave_hold;
  assign irq        = |(status_r & mask_r);

  // Controls to the byte engine
  always_comb begin
    ctl           = '0;
    ctl.ack_go    = ack_go_r;
    ctl.ack_nack  = nack_r;
    ctl.auto_nack = auto_nack;
    ctl.auto_stop = auto_stop;
    ctl.tx_valid  = !tx_req_r;
    ctl.tx_data   = tx_data_r;
  end

  // ----------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------------------------------
  logic [31:0] rdata_r, rdata_nxt;

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (reg_rd) begin
      if (reg_addr == OFS_CONTROL_A) begin
        rdata_nxt = {28'h0, ctrl_a_r};
      end else if (reg_addr == OFS_CONTROL_B) begin
        rdata_nxt = {30'h0, ctrl_b_r};
      end else if (reg_addr == OFS_LENGTH) begin
        rdata_nxt = {23'h0, length_r};
      end else if (reg_addr == OFS_DATA) begin
        rdata_nxt = {24'h0, rx_data_r};
      end else if (reg_addr == OFS_STATUS) begin
        rdata_nxt = {24'h0, status_r};
      end else if (reg_addr == OFS_MASK) begin
        rdata_nxt = {24'h0, mask_r};
      end else if (reg_addr == OFS_STATE) begin
        rdata_nxt = {20'h0, left_r, len_act_r, tx_req_r, rx_req_r, four_wire};
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

endmodule : sxe_ext

`default_nettype wire

// *** verif/sxe_ext_props.sv ***
// Purpose : Port checks for the bus extension block
// Assumes : Bound from the bench top, one clock domain
// Notes   : Watches design outputs against their causes
`timescale 1ns/1ps
`default_nettype none
module sxe_ext_props
  import sxe_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_rdata,
  input  wire sxe_core_t   core,
  input  wire sxe_ctl_t    ctl,
  input  wire logic        dma_rx_req,
  input  wire logic        dma_tx_req,
  input  wire logic        pad_scl_oe,
  input  wire logic        ext_scl_o
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Request and answer relations
  a_rdata_idle: assert property (reg_rdata != 0 |-> $past(reg_rd))
    else $error("read data without a read");
  a_rx_rise: assert property (core.rx_byte && core.is_master |=> dma_rx_req)
    else $error("receive request missing");
  a_rx_drop: assert property (reg_rd && reg_addr == OFS_DATA && !core.rx_byte |=> !dma_rx_req)
    else $error("receive request kept after read");
  a_tx_rise: assert property (core.tx_need && core.is_master |=> dma_tx_req)
    else $error("transmit request missing");
  a_tx_drop: assert property (reg_wr && reg_addr == OFS_DATA && !core.tx_need |=> !dma_tx_req)
    else $error("transmit request kept after write");
  a_smart_ack: assert property ($rose(ctl.ack_go) |-> $past(reg_rd) && $past(reg_addr) == OFS_DATA)
    else $error("ack sent without a data read");
  a_four_wire: assert property (!ext_scl_o |-> !pad_scl_oe)
    else $error("internal driver on in four-wire mode");
  a_auto_nack: assert property (ctl.auto_nack |-> ctl.auto_stop && core.is_read)
    else $error("automatic nack without stop");
  // Main scenarios reached
  c_nack: cover property (ctl.auto_nack);
  c_rx: cover property (dma_rx_req && core.is_master);
  c_four: cover property (!ext_scl_o);
endmodule : sxe_ext_props
`default_nettype wire

// *** verif/sxe_bus_model.sv ***
// Purpose : Two-wire bus lines with pull-ups and an external driver
// Assumes : Released lines float high
// Notes   : Both pin pairs see the same bus level
`timescale 1ns/1ps
`default_nettype none
module sxe_bus_model (
  input  wire logic pad_scl_oe,
  input  wire logic pad_sda_oe,
  input  wire logic ext_scl_o,
  input  wire logic ext_sda_o,
  output logic      pad_scl_i,
  output logic      pad_sda_i,
  output logic      ext_scl_i,
  output logic      ext_sda_i
);
  // Wired-AND of the internal pull-down and the external driver
  assign pad_scl_i = !pad_scl_oe && ext_scl_o;
  assign pad_sda_i = !pad_sda_oe && ext_sda_o;
  assign ext_scl_i = pad_scl_i;
  assign ext_sda_i = pad_sda_i;
endmodule : sxe_bus_model
`default_nettype wire

// *** verif/sxe_ext_test.sv ***
// Purpose : Register-level bench for the bus extension block
// Assumes : 200 MHz mclk, 64 ns slow timing clock
// Notes   : Engine events are driven on the core carrier
`timescale 1ns/1ps
`default_nettype none
module sxe_ext_test
  import sxe_pkg::*;
;
  localparam logic [20:0] M_RX = 21'h40000, M_TX = 21'h20000, M_ACK = 21'h10000;
  localparam logic [20:0] M_AACK = 21'h08000, M_AM = 21'h04000, M_NACK = 21'h01000;
  logic        mclk = 0, rst = 1, reg_wr = 0, reg_rd = 0, slow = 0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
  sxe_core_t   core = '0;
  sxe_ctl_t    ctl;
  logic        dma_rx_req, dma_tx_req, irq, pad_scl_oe, pad_sda_oe, ext_scl_o, ext_sda_o;
  logic        pad_scl_i, pad_sda_i, ext_scl_i, ext_sda_i, line_scl, line_sda;
  logic [7:0]  offs [5] = '{OFS_CONTROL_A, OFS_CONTROL_B, OFS_LENGTH, OFS_MASK, 8'h1C};
  int          fail_count = 0, num_checks = 0, n;
  always #2.5 mclk = ~mclk;
  always #32 slow = ~slow;
  sxe_ext uut (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .slow_timeout_clock(slow), .core, .ctl, .line_scl, .line_sda, .dma_rx_req, .dma_tx_req,
    .irq, .pad_scl_i, .pad_scl_o(), .pad_scl_oe, .pad_sda_i, .pad_sda_o(), .pad_sda_oe,
    .ext_scl_i, .ext_sda_i, .ext_scl_o, .ext_sda_o);
  sxe_bus_model bus (.pad_scl_oe, .pad_sda_oe, .ext_scl_o, .ext_sda_o, .pad_scl_i, .pad_sda_i,
    .ext_scl_i, .ext_sda_i);
  // Verdict and end of run
  task automatic test_done;
    if (fail_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Register write and read cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rdc
  // Engine level and one-cycle event
  task automatic set(input int b, input logic val);
    @(posedge mclk);
    core[b] <= val;
  endtask : set
  task automatic pulse(input logic [20:0] m, input logic [1:0] e);
    @(posedge mclk);
    core <= core | m;
    #1 chk({30'h0, ctl.auto_stop, ctl.auto_nack}, {30'h0, e});
    @(posedge mclk);
    core <= core & ~m;
    #1;
  endtask : pulse
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    foreach (offs[i]) rdc(offs[i], 32'h0);
    // Master smart read with ack and with nack
    set(20, 1'b1);
    for (int k = 0; k < 2; k++) begin
      wr(OFS_CONTROL_B, 32'(1 + 2 * k));
      pulse(M_RX | 21'hA5, 2'b00);
      chk(32'(dma_rx_req), 32'h1);
      rdc(OFS_DATA, 32'hA5);
      chk(32'({ctl.ack_go, ctl.ack_nack}), 32'(2 + k));
      chk(32'(dma_rx_req), 32'h0);
    end
    // Master and slave transmit requests
    for (int k = 1; k >= 0; k--) begin
      set(20, k[0]);
      pulse(M_TX, 2'b00);
      chk(32'(dma_tx_req), 32'h1);
      wr(OFS_DATA, 32'(8'h3C + k));
      #1 chk(32'(dma_tx_req), 32'h0);
      chk(32'({ctl.tx_valid, ctl.tx_data}), 32'h13C + k);
    end
    // Slave requests held until address match is serviced
    wr(OFS_MASK, 32'h80);
    pulse(M_AM, 2'b00);
    chk(32'(irq), 32'h1);
    pulse(M_RX | 21'h5A, 2'b00);
    chk(32'(dma_rx_req), 32'h0);
    rdc(OFS_STATUS, 32'h80);
    chk(32'({irq, dma_rx_req}), 32'h1);
    rdc(OFS_DATA, 32'h5A);
    chk(32'(dma_rx_req), 32'h0);
    // Length counting: read of two bytes, empty write, early nack
    set(20, 1'b1);
    set(19, 1'b1);
    wr(OFS_LENGTH, 32'h102);
    pulse(M_ACK | M_AACK, 2'b00);
    pulse(M_ACK, 2'b00);
    pulse(M_ACK, 2'b11);
    set(19, 1'b0);
    wr(OFS_LENGTH, 32'h100);
    pulse(M_ACK | M_AACK, 2'b10);
    wr(OFS_LENGTH, 32'h103);
    pulse(M_NACK, 2'b10);
    rdc(OFS_STATUS, 32'h48);
    // Single low period timeout and data hold after clock falls
    wr(OFS_CONTROL_A, 32'h1);
    wr(OFS_MASK, 32'h1);
    set(9, 1'b1);
    set(8, 1'b1);
    repeat (30) @(posedge mclk);
    #1 chk(32'({pad_sda_oe, pad_scl_oe, ext_scl_o}), 32'h3);
    repeat (50) @(posedge mclk);
    #1 chk(32'(pad_sda_oe), 32'h1);
    for (n = 82; n < 11000 && irq !== 1'b1; n++) @(posedge mclk);
    if (n == 11000) begin
      fail_count++;
      test_done();
    end
    chk(32'(n > 10200), 32'h1);
    set(9, 1'b0);
    set(8, 1'b0);
    rdc(OFS_STATUS, 32'h41);
    chk(32'(irq), 32'h0);
    // Four-wire mode bypasses the internal driver
    wr(OFS_CONTROL_A, 32'h8);
    set(9, 1'b1);
    repeat (4) @(posedge mclk);
    #1 chk(32'({pad_scl_oe, ext_scl_o, ext_sda_o, line_scl, line_sda}), 32'h5);
    set(9, 1'b0);
    test_done();
  end
endmodule : sxe_ext_test
bind sxe_ext sxe_ext_props chk_i (.mclk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .core,
  .ctl, .dma_rx_req, .dma_tx_req, .pad_scl_oe, .ext_scl_o);
`default_nettype wire
